// file: tmt_pkg.sv
// Purpose: shared constants and types for the tap and motion timing block
// Assumes: 40 MHz system clock, 8-bit register port behind the serial engine
// Notes:   offsets are the serial register addresses
package tmt_pkg;

   // ==========================================================
   // register addresses
   localparam logic [7:0] ADDR_TILT_DEBOUNCE = 8'h28;
   localparam logic [7:0] ADDR_MOTION_DEBOUNCE = 8'h29;
   localparam logic [7:0] ADDR_GAP = 8'h2b;
   localparam logic [7:0] ADDR_UPPER_THR = 8'h2c;
   localparam logic [7:0] ADDR_LOWER_THR = 8'h2d;
   localparam logic [7:0] ADDR_DURATION = 8'h2e;
   localparam logic [7:0] ADDR_TOTAL = 8'h2f;
   localparam logic [7:0] ADDR_LATENCY = 8'h30;

   // ==========================================================
   // values after reset
   localparam logic [7:0] RST_TILT_DEBOUNCE = 8'h00;
   localparam logic [7:0] RST_MOTION_DEBOUNCE = 8'h00;
   localparam logic [7:0] RST_GAP = 8'h78;
   localparam logic [7:0] RST_UPPER_THR = 8'hcb;
   localparam logic [7:0] RST_LOWER_THR = 8'h1a;
   localparam logic [7:0] RST_DURATION = 8'ha2;
   localparam logic [7:0] RST_TOTAL = 8'h24;
   localparam logic [7:0] RST_LATENCY = 8'h28;

   // ==========================================================
   // field positions
   localparam int LOWER_THR_MSB = 6;
   localparam int UPPER_LSB_POS = 7;
   localparam int DUR_LOW_MSB = 2;
   localparam int DUR_HIGH_LSB = 3;

   // ==========================================================
   // tap rate codes and count scaling
   localparam logic [2:0] TAP_RATE_800 = 3'h6;
   localparam logic [2:0] TAP_RATE_1600 = 3'h7;
   localparam logic [1:0] SCALE_LIM_1 = 2'h0;
   localparam logic [1:0] SCALE_LIM_2 = 2'h1;
   localparam logic [1:0] SCALE_LIM_4 = 2'h3;

   // ==========================================================
   // motion rate timing
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned MOTION_FAST_HZ = 200;
   localparam int unsigned MOTION_FAST_CYC = CLK_HZ / MOTION_FAST_HZ;
   localparam logic [1:0] MOTION_RATE_SLOWEST = 2'h3;

   // ==========================================================
   // tap sequencer states
   typedef enum logic [2:0] {
      TMT_IDLE,
      TMT_FIRST,
      TMT_GAP,
      TMT_SECOND,
      TMT_HOLD
   } tmt_tap_st_t;

endpackage

// file: tmt_core.sv
// Purpose: tilt and motion debounce, jerk index and single/double tap timing
// Assumes: sample, tick and candidate inputs come from logic on i_clk
// Notes:   register port is the parallel side of the serial slave
//
// Notes on behaviour
// - a tilt candidate is accepted only after holding for the programmed tilt count of ticks.
// - a motion candidate is accepted only after holding for the programmed motion count of ticks.
// - one tap count is one sample at 400 Hz or lower, two at 800 Hz, four at 1600 Hz.
// - a second tap counts only after at least the gap count has passed since the first.
// - the effective upper jerk threshold is twice the upper register plus bit 7 of the lower register, 0 to 511.
// - the jerk index is the sum of absolute per-axis differences to the previous sample.
// - a sample qualifies when its jerk index is above the low and below the upper threshold.
// - bit 7 of the lower register is the upper threshold's low bit, bits 6:0 the low threshold.
// - a tap lasts at least the 3-bit low limit and at most the 5-bit high limit; the code counts duration only up to the latency count, so longer taps can pass.
// - both taps of a double tap together stay within the total count.
// - above-threshold samples of one tap are counted no further than the latency count.
// - a single tap is reported when the window ends, not when the tap ends.
// - registers reset to their documented values.
// - the motion rate code selects 25, 50, 100 or 200 Hz.
// - a whole single or double tap event lies inside the tap window count.
module tmt_core #(
   parameter int unsigned MOTION_FAST_CYC_P = tmt_pkg::MOTION_FAST_CYC
) (
   input  wire logic               i_clk,
   input  wire logic               i_sys_rst,
   input  wire logic [7:0]         i_reg_addr,
   input  wire logic               i_reg_wr,
   input  wire logic               i_reg_rd,
   input  wire logic [7:0]         i_reg_wdata,
   output logic      [7:0]         o_reg_rdata,
   input  wire logic               i_sample_valid,
   input  wire logic signed [11:0] i_acc_x,
   input  wire logic signed [11:0] i_acc_y,
   input  wire logic signed [11:0] i_acc_z,
   input  wire logic [2:0]         i_tap_rate,
   input  wire logic [7:0]         i_tap_window_count,
   input  wire logic               i_tilt_tick,
   input  wire logic [5:0]         i_tilt_cand,
   input  wire logic [1:0]         i_motion_rate_sel,
   input  wire logic               i_motion_cand,
   output logic      [5:0]         o_tilt_state,
   output logic                    o_motion_state,
   output logic                    o_motion_tick,
   output logic      [13:0]        o_jerk_index,
   output logic                    o_single_tap,
   output logic                    o_double_tap
);

   // ==========================================================
   // state
   typedef struct packed {
      logic [7:0]         tilt_reg;
      logic [7:0]         mot_reg;
      logic [7:0]         gap_reg;
      logic [7:0]         up_reg;
      logic [7:0]         lo_reg;
      logic [7:0]         dur_reg;
      logic [7:0]         tot_reg;
      logic [7:0]         lat_reg;
      logic [7:0]         rdata;
      logic signed [11:0] px;
      logic signed [11:0] py;
      logic signed [11:0] pz;
      logic [13:0]        jerk;
      logic               jvalid;
      logic [5:0]         tilt_cand;
      logic [5:0]         tilt_state;
      logic [7:0]         tilt_timer;
      logic [23:0]        mot_div;
      logic               mot_cand;
      logic               mot_state;
      logic [7:0]         mot_timer;
      logic [1:0]         scale;
      tmt_pkg::tmt_tap_st_t st;
      logic [7:0]         win;
      logic [7:0]         dur;
      logic [7:0]         lat;
      logic [8:0]         tot;
      logic [7:0]         gap;
      logic               single;
      logic               dbl;
   } tmt_state_t;

   tmt_state_t s;
   tmt_state_t n;

   logic [1:0]  scale_lim;
   logic        unit_tick;
   logic        above;
   logic        dur_ok;
   logic [23:0] mot_lim;
   logic [13:0] jerk_now;
   logic [12:0] upper_eff;

   function automatic logic [11:0] tmt_absdiff(input logic signed [11:0] a,
                                               input logic signed [11:0] b);
      logic signed [12:0] d;
      d = {a[11], a} - {b[11], b};
      return d[12] ? 12'(-d) : d[11:0];
   endfunction

   // ==========================================================
   // combinational helpers
   always_comb begin
      jerk_now = {2'h0, tmt_absdiff(i_acc_x, s.px)} + {2'h0, tmt_absdiff(i_acc_y, s.py)}
               + {2'h0, tmt_absdiff(i_acc_z, s.pz)};
      if (i_tap_rate == tmt_pkg::TAP_RATE_1600) begin
         scale_lim = tmt_pkg::SCALE_LIM_4;
      end else if (i_tap_rate == tmt_pkg::TAP_RATE_800) begin
         scale_lim = tmt_pkg::SCALE_LIM_2;
      end else begin
         scale_lim = tmt_pkg::SCALE_LIM_1;
      end
      unit_tick = s.jvalid && (s.scale == scale_lim);
      upper_eff = {4'h0, s.up_reg, s.lo_reg[tmt_pkg::UPPER_LSB_POS]};
      above = (s.jerk > {7'h0, s.lo_reg[tmt_pkg::LOWER_THR_MSB:0]})
           && (s.jerk < {1'b0, upper_eff});
      dur_ok = (s.dur >= {5'h0, s.dur_reg[tmt_pkg::DUR_LOW_MSB:0]})
            && (s.dur <= {3'h0, s.dur_reg[7:tmt_pkg::DUR_HIGH_LSB]});
      mot_lim = 24'(MOTION_FAST_CYC_P) << (tmt_pkg::MOTION_RATE_SLOWEST - i_motion_rate_sel);
   end

   // ==========================================================
   // next state
   always_comb begin
      n = s;
      n.single = 1'b0;
      n.dbl = 1'b0;
      // register port
      if (i_reg_wr) begin
         case (i_reg_addr)
            tmt_pkg::ADDR_TILT_DEBOUNCE:   n.tilt_reg = i_reg_wdata;
            tmt_pkg::ADDR_MOTION_DEBOUNCE: n.mot_reg = i_reg_wdata;
            tmt_pkg::ADDR_GAP:             n.gap_reg = i_reg_wdata;
            tmt_pkg::ADDR_UPPER_THR:       n.up_reg = i_reg_wdata;
            tmt_pkg::ADDR_LOWER_THR:       n.lo_reg = i_reg_wdata;
            tmt_pkg::ADDR_DURATION:        n.dur_reg = i_reg_wdata;
            tmt_pkg::ADDR_TOTAL:           n.tot_reg = i_reg_wdata;
            tmt_pkg::ADDR_LATENCY:         n.lat_reg = i_reg_wdata;
            default:                       n.rdata = s.rdata;
         endcase
      end
      if (i_reg_rd) begin
         case (i_reg_addr)
            tmt_pkg::ADDR_TILT_DEBOUNCE:   n.rdata = s.tilt_reg;
            tmt_pkg::ADDR_MOTION_DEBOUNCE: n.rdata = s.mot_reg;
            tmt_pkg::ADDR_GAP:             n.rdata = s.gap_reg;
            tmt_pkg::ADDR_UPPER_THR:       n.rdata = s.up_reg;
            tmt_pkg::ADDR_LOWER_THR:       n.rdata = s.lo_reg;
            tmt_pkg::ADDR_DURATION:        n.rdata = s.dur_reg;
            tmt_pkg::ADDR_TOTAL:           n.rdata = s.tot_reg;
            tmt_pkg::ADDR_LATENCY:         n.rdata = s.lat_reg;
            default:                       n.rdata = 8'h00;
         endcase
      end
      // jerk index per sample
      n.jvalid = i_sample_valid;
      if (i_sample_valid) begin
         n.px = i_acc_x;
         n.py = i_acc_y;
         n.pz = i_acc_z;
         n.jerk = jerk_now;
      end
      if (s.jvalid) begin
         n.scale = unit_tick ? 2'h0 : s.scale + 2'h1;
      end
      // tilt debounce
      n.tilt_cand = i_tilt_cand;
      if (i_tilt_cand != s.tilt_cand) begin
         n.tilt_timer = s.tilt_reg;
      end else if (i_tilt_tick && (s.tilt_cand != s.tilt_state)) begin
         if (s.tilt_timer == 8'h00) begin
            n.tilt_state = s.tilt_cand;
            n.tilt_timer = s.tilt_reg;
         end else begin
            n.tilt_timer = s.tilt_timer - 8'h01;
         end
      end
      // motion rate divider and debounce
      n.mot_div = o_motion_tick ? 24'h0 : s.mot_div + 24'h1;
      n.mot_cand = i_motion_cand;
      if (i_motion_cand != s.mot_cand) begin
         n.mot_timer = s.mot_reg;
      end else if (o_motion_tick && (s.mot_cand != s.mot_state)) begin
         if (s.mot_timer == 8'h00) begin
            n.mot_state = s.mot_cand;
            n.mot_timer = s.mot_reg;
         end else begin
            n.mot_timer = s.mot_timer - 8'h01;
         end
      end
      // tap sequencer
      if (unit_tick) begin
         if (s.win != 8'hff) begin
            n.win = s.win + 8'h01;
         end
         case (s.st)
            tmt_pkg::TMT_IDLE: begin
               if (above) begin
                  n.st = tmt_pkg::TMT_FIRST;
                  n.win = 8'h01;
                  n.dur = 8'h01;
                  n.lat = 8'h01;
                  n.tot = 9'h001;
               end
            end
            tmt_pkg::TMT_FIRST, tmt_pkg::TMT_SECOND: begin
               if (s.win >= i_tap_window_count) begin
                  n.st = tmt_pkg::TMT_IDLE;
                  n.single = (s.st == tmt_pkg::TMT_SECOND);
               end else if (above) begin
                  if (s.lat < s.lat_reg) begin
                     n.dur = s.dur + 8'h01;
                     n.lat = s.lat + 8'h01;
                     n.tot = s.tot + 9'h001;
                  end
               end else if (s.st == tmt_pkg::TMT_FIRST) begin
                  n.st = dur_ok ? tmt_pkg::TMT_GAP : tmt_pkg::TMT_IDLE;
                  n.gap = 8'h01;
               end else if (dur_ok && (s.tot <= {1'b0, s.tot_reg})) begin
                  n.st = tmt_pkg::TMT_HOLD;
                  n.dbl = 1'b1;
               end else begin
                  n.st = tmt_pkg::TMT_GAP;
                  n.gap = 8'h01;
               end
            end
            tmt_pkg::TMT_GAP: begin
               if (s.gap != 8'hff) begin
                  n.gap = s.gap + 8'h01;
               end
               if (s.win >= i_tap_window_count) begin
                  n.st = tmt_pkg::TMT_IDLE;
                  n.single = 1'b1;
               end else if (above && (s.gap >= s.gap_reg)) begin
                  n.st = tmt_pkg::TMT_SECOND;
                  n.dur = 8'h01;
                  n.lat = 8'h01;
                  n.tot = s.tot + 9'h001;
               end
            end
            tmt_pkg::TMT_HOLD: begin
               if (s.win >= i_tap_window_count) begin
                  n.st = tmt_pkg::TMT_IDLE;
               end
            end
            default: n.st = tmt_pkg::TMT_IDLE;
         endcase
      end
      if (i_sys_rst) begin
         n = '0;
         n.st = tmt_pkg::TMT_IDLE;
         n.tilt_reg = tmt_pkg::RST_TILT_DEBOUNCE;
         n.mot_reg = tmt_pkg::RST_MOTION_DEBOUNCE;
         n.gap_reg = tmt_pkg::RST_GAP;
         n.up_reg = tmt_pkg::RST_UPPER_THR;
         n.lo_reg = tmt_pkg::RST_LOWER_THR;
         n.dur_reg = tmt_pkg::RST_DURATION;
         n.tot_reg = tmt_pkg::RST_TOTAL;
         n.lat_reg = tmt_pkg::RST_LATENCY;
      end
   end

   always_ff @(posedge i_clk) begin
      s <= n;
   end

   // ==========================================================
   // outputs
   assign o_reg_rdata = s.rdata;
   assign o_tilt_state = s.tilt_state;
   assign o_motion_state = s.mot_state;
   assign o_motion_tick = (s.mot_div >= mot_lim - 24'h1);
   assign o_jerk_index = s.jerk;
   assign o_single_tap = s.single;
   assign o_double_tap = s.dbl;

   // ==========================================================
   // assertions
   a_reset_values: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      $past(i_sys_rst) |->
      s.up_reg == 8'hcb && s.lo_reg == 8'h1a && s.tilt_reg == 8'h00 && s.gap_reg == 8'h78)
      else $error("register reset value wrong");
   a_jerk_sum: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_sample_valid |=> s.jvalid && s.jerk == $past(jerk_now))
      else $error("jerk index wrong");
   a_scale_four: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      unit_tick && i_tap_rate == 3'h7 |-> s.scale == 2'h3)
      else $error("1600 Hz count not four samples");
   a_tilt_accept: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      s.tilt_state != $past(s.tilt_state) |-> $past(i_tilt_tick) && $past(s.tilt_timer) == 8'h00)
      else $error("tilt accepted early");
   a_motion_accept: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      s.mot_state != $past(s.mot_state) |-> $past(o_motion_tick) && $past(s.mot_timer) == 8'h00)
      else $error("motion accepted early");
   a_reload_cand: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      i_tilt_cand != s.tilt_cand |=> s.tilt_timer == $past(s.tilt_reg))
      else $error("tilt timer not reloaded");
   a_qual_start: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      s.st == tmt_pkg::TMT_IDLE ##1 s.st == tmt_pkg::TMT_FIRST |->
      $past(s.jerk) > {7'h0, $past(s.lo_reg[6:0])} &&
      $past(s.jerk) < {5'h0, $past(s.up_reg), $past(s.lo_reg[7])})
      else $error("tap started outside thresholds");
   a_dur_limit: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      s.st == tmt_pkg::TMT_FIRST ##1 s.st == tmt_pkg::TMT_GAP |->
      $past(s.dur) >= {5'h0, $past(s.dur_reg[2:0])} && $past(s.dur) <= {3'h0, $past(s.dur_reg[7:3])})
      else $error("tap duration outside limits");
   a_gap_min: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      s.st == tmt_pkg::TMT_GAP ##1 s.st == tmt_pkg::TMT_SECOND |-> $past(s.gap) >= $past(s.gap_reg))
      else $error("second tap too soon");
   a_total_time: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_double_tap |-> $past(s.tot) <= {1'b0, s.tot_reg} && s.st == tmt_pkg::TMT_HOLD)
      else $error("double tap over total time");
   a_latency_cap: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      s.st == tmt_pkg::TMT_FIRST |-> s.lat <= s.lat_reg || s.lat == 8'h01)
      else $error("latency count exceeded");
   a_single_window: assert property (@(posedge i_clk) disable iff (i_sys_rst)
      o_single_tap |-> $past(s.win) >= $past(i_tap_window_count) && s.st == tmt_pkg::TMT_IDLE)
      else $error("single tap before window end");

endmodule

// file: tmt_host.sv
// Purpose: host side model that drives the register port of the timing block
// Assumes: each request changes just after a rising edge and holds one full cycle
// Notes:   a released address or data bus shows the inverse of its last value
module tmt_host (
   input  wire logic       i_clk,
   input  wire logic [7:0] i_rdata,
   output logic      [7:0] o_addr,
   output logic            o_wr,
   output logic            o_rd,
   output logic      [7:0] o_wdata
);
   timeunit 1ns;
   timeprecision 1ps;

   logic operating_mode_bit;

   initial begin
      operating_mode_bit = 1'b1;
      o_addr = 8'h00;
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_wdata = 8'h00;
   end

   // ==========================================================
   // single byte write and read
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      operating_mode_bit = 1'b0;
      @(posedge i_clk);
      o_addr <= a;
      o_wdata <= d;
      o_wr <= 1'b1;
      @(posedge i_clk);
      o_wr <= 1'b0;
      o_addr <= ~a;
      o_wdata <= ~d;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      o_addr <= a;
      o_rd <= 1'b1;
      @(posedge i_clk);
      o_rd <= 1'b0;
      o_addr <= ~a;
      @(posedge i_clk);
      #1;
      d = i_rdata;
   endtask
endmodule

// file: test_tap_and_motion_timing.sv
// Purpose: self-checking bench for the tap and motion timing block
// Assumes: fast motion divider shortened to 8 cycles, tap window input 10
// Notes:   each scenario is one task that drives and judges
`define CHK(got, exp) \
   begin \
      checks++; \
      if ((got) !== (exp)) begin \
         fail_count++; \
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); \
      end \
   end
module test_tap_and_motion_timing;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int FAST = 8;
   logic        clk, rst, wr, rd, sv, ttick, mcand, mstate, mtick, stap, dtap;
   logic [7:0]  addr, wdata, rdata, win;
   logic [11:0] ax, ay, az;
   logic [2:0]  rate;
   logic [5:0]  tcand, tstate;
   logic [1:0]  msel;
   logic [13:0] jerk;
   int          fail_count, checks, ns, nd, fs, nsmp, xv;
   logic [7:0]  rv [8] = '{8'h00, 8'h00, 8'h78, 8'hcb, 8'h1a, 8'ha2, 8'h24, 8'h28};

   tmt_core #(.MOTION_FAST_CYC_P(FAST)) dut (
      .i_clk(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd),
      .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_sample_valid(sv), .i_acc_x(ax),
      .i_acc_y(ay), .i_acc_z(az), .i_tap_rate(rate), .i_tap_window_count(win),
      .i_tilt_tick(ttick), .i_tilt_cand(tcand), .i_motion_rate_sel(msel),
      .i_motion_cand(mcand), .o_tilt_state(tstate), .o_motion_state(mstate),
      .o_motion_tick(mtick), .o_jerk_index(jerk), .o_single_tap(stap),
      .o_double_tap(dtap));

   tmt_host host (.i_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr), .o_rd(rd),
      .o_wdata(wdata));

   // ==========================================================
   // clock, pulse counters, watchdog
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) begin
      if (stap === 1'b1 && fs < 0) fs = nsmp;
      if (stap === 1'b1) ns++;
      if (dtap === 1'b1) nd++;
   end

   initial begin
      #500us;
      fail_count++;
      print_verdict();
   end

   // ==========================================================
   // shared tasks
   task automatic print_verdict();
      $display("checks=%0d fail_count=%0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic send(input logic [11:0] x, input logic [11:0] y, input logic [11:0] z);
      @(posedge clk);
      sv <= 1'b1;
      ax <= x;
      ay <= y;
      az <= z;
      @(posedge clk);
      sv <= 1'b0;
      @(posedge clk);
      #1;
   endtask

   task automatic tilt_pulse();
      @(posedge clk);
      ttick <= 1'b1;
      @(posedge clk);
      ttick <= 1'b0;
      #1;
   endtask

   task automatic wait_mtick(output int n);
      n = 0;
      do begin
         @(posedge clk);
         #1;
         n++;
      end while (mtick !== 1'b1 && n < 300);
   endtask

   // q units alternate x by amp, n units repeat x
   task automatic tap_case(input string p, input int amp, sc, es, ed);
      int u0;
      u0 = -1;
      ns = 0;
      nd = 0;
      fs = -1;
      for (int k = 0; k < 26 * sc; k++) begin
         nsmp = k / sc;
         if (nsmp < p.len() && p[nsmp] == "q") begin
            if (u0 < 0) u0 = nsmp;
            xv = (xv >= amp) ? xv - amp : xv + amp;
         end
         send(12'(xv), 12'h000, 12'h000);
      end
      `CHK(ns, es)
      `CHK(nd, ed)
      if (es == 1) `CHK(fs >= u0 + 8 && fs <= u0 + 11, 1'b1)
   endtask

   // ==========================================================
   // scenarios
   task automatic t_regs();
      logic [7:0] d;
      for (int i = 0; i < 8; i++) begin
         host.rd((i < 2) ? 8'(8'h28 + i) : 8'(8'h29 + i), d);
         `CHK(d, rv[i])
         host.wr((i < 2) ? 8'(8'h28 + i) : 8'(8'h29 + i), ~rv[i]);
         host.rd((i < 2) ? 8'(8'h28 + i) : 8'(8'h29 + i), d);
         `CHK(d, ~rv[i])
      end
      host.wr(8'h2a, 8'hff);
      host.rd(8'h2a, d);
      `CHK(d, 8'h00)
      $display("registers test done");
   endtask

   task automatic t_tilt();
      host.wr(8'h28, 8'h03);
      @(posedge clk);
      tcand <= 6'h05;
      tilt_pulse();
      tilt_pulse();
      @(posedge clk);
      tcand <= 6'h0a;
      repeat (3) tilt_pulse();
      `CHK(tstate, 6'h00)
      tilt_pulse();
      `CHK(tstate, 6'h0a)
      $display("tilt test done");
   endtask

   task automatic t_motion();
      int n;
      for (int c = 0; c < 4; c++) begin
         @(posedge clk);
         msel <= 2'(c);
         wait_mtick(n);
         wait_mtick(n);
         wait_mtick(n);
         `CHK(n, FAST << (3 - c))
      end
      host.wr(8'h29, 8'h02);
      wait_mtick(n);
      @(posedge clk);
      mcand <= 1'b1;
      n = 0;
      for (int k = 0; k < 100 && mstate !== 1'b1; k++) begin
         @(posedge clk);
         #1;
         if (mstate !== 1'b1 && mtick === 1'b1) n++;
      end
      `CHK(n, 3)
      $display("motion test done");
   endtask

   task automatic t_taps();
      host.wr(8'h2c, 8'h20);
      host.wr(8'h2d, 8'h0a);
      host.wr(8'h2e, 8'h19);
      host.wr(8'h2b, 8'h02);
      host.wr(8'h2f, 8'h0a);
      host.wr(8'h30, 8'h08);
      for (int r = 0; r < 8; r++) begin
         @(posedge clk);
         rate <= 3'(r);
         tap_case("nqn", 20, (r == 7) ? 4 : (r == 6) ? 2 : 1, 1, 0);
      end
      @(posedge clk);
      rate <= 3'h0;
      tap_case("nqnnnnqn", 20, 1, 0, 1);
      tap_case("nqnqn", 20, 1, 1, 0);
      tap_case("nqqqqqn", 20, 1, 0, 0);
      tap_case("nqn", 10, 1, 0, 0);
      tap_case("nqn", 11, 1, 1, 0);
      tap_case("nqn", 64, 1, 0, 0);
      host.wr(8'h2d, 8'h8a);
      tap_case("nqn", 64, 1, 1, 0);
      host.wr(8'h30, 8'h02);
      tap_case("nqqqqqn", 20, 1, 1, 0);
      host.wr(8'h2f, 8'h02);
      tap_case("nqqnnnqqn", 20, 1, 1, 0);
      $display("tap test done");
   endtask

   task automatic t_jerk();
      send(12'h000, 12'h000, 12'h000);
      send(12'sd5, -12'sd7, 12'sd100);
      `CHK(jerk, 14'd112)
      send(-12'sd3, 12'sd2, 12'sd90);
      `CHK(jerk, 14'd27)
      $display("jerk test done");
   endtask

   // ==========================================================
   // main sequence
   initial begin
      rst = 1'b1;
      sv = 1'b0;
      ax = 12'h000;
      ay = 12'h000;
      az = 12'h000;
      rate = 3'h0;
      win = 8'h0a;
      ttick = 1'b0;
      tcand = 6'h00;
      msel = 2'h1;
      mcand = 1'b0;
      xv = 0;
      fs = -1;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_tilt();
      t_motion();
      t_taps();
      t_jerk();
      print_verdict();
   end
endmodule
